// ### design/gp_pkg.sv
// Constants, carriers and decode helpers for the general-purpose port block.
// Assumes a single 200 MHz system clock and an AHB-Lite register bus of 32 bits.
package gp_pkg;

  localparam int GP_PORTS = 5;
  localparam int GP_CFG_REGS = 9;

  // Port slots: each port owns a 64-byte window; the system slot follows port E.
  localparam logic [2:0] GP_PORT_A = 3'h0;
  localparam logic [2:0] GP_PORT_B = 3'h1;
  localparam logic [2:0] GP_PORT_C = 3'h2;
  localparam logic [2:0] GP_PORT_D = 3'h3;
  localparam logic [2:0] GP_PORT_SYS = 3'h5;
  localparam int GP_PORT_LSB = 6;
  localparam int GP_IDX_LSB = 2;

  // Word index of each register inside a port window.
  localparam logic [3:0] GP_REG_OUT = 4'h0;
  localparam logic [3:0] GP_REG_DIR = 4'h1;
  localparam logic [3:0] GP_REG_ALT = 4'h2;
  localparam logic [3:0] GP_REG_ALT_FUNC_SET_FIRST = 4'h3;
  localparam logic [3:0] GP_REG_ALT_FUNC_SET_SECOND = 4'h4;
  localparam logic [3:0] GP_REG_OD = 4'h5;
  localparam logic [3:0] GP_REG_HD = 4'h6;
  localparam logic [3:0] GP_REG_PU = 4'h7;
  localparam logic [3:0] GP_REG_WAKE = 4'h8;
  localparam logic [3:0] GP_REG_IN = 4'h9;
  localparam logic [3:0] GP_REG_LED0 = 4'hA;
  localparam logic [3:0] GP_REG_LED1 = 4'hB;
  localparam logic [3:0] GP_REG_SYS = 4'h0;

  // Reset values: every pin an input, everything else off.
  localparam logic [7:0] GP_DIR_RST = 8'hFF;
  localparam logic [7:0] GP_CFG_RST = 8'h00;

  // System register bits.
  localparam int GP_SYS_RST_GPIO_BIT = 0;
  localparam int GP_SYS_XTAL_BIT = 1;
  localparam int GP_SYS_LOSC_BIT = 2;

  // LED sink current levels, {LED1 bit, LED0 bit}.
  localparam logic [1:0] GP_LED_3MA = 2'h0;
  localparam logic [1:0] GP_LED_7MA = 2'h1;
  localparam logic [1:0] GP_LED_13MA = 2'h2;
  localparam logic [1:0] GP_LED_20MA = 2'h3;

  localparam logic [1:0] GP_HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic out;
    logic oe;
    logic od;
    logic hd;
    logic pu;
    logic wake;
    logic led_en;
    logic [1:0] led_lvl;
  } gp_pin_ctl_t;

  typedef gp_pin_ctl_t [7:0] gp_port_ctl_t;

  // Implemented pins of each port.
  function automatic logic [7:0] gp_port_mask(input logic [2:0] p);
    case (p)
      3'h0: gp_port_mask = 8'hFF;
      3'h1: gp_port_mask = 8'h3F;
      3'h2: gp_port_mask = 8'hFF;
      3'h3: gp_port_mask = 8'hFF;
      3'h4: gp_port_mask = 8'h7F;
      default: gp_port_mask = 8'h00;
    endcase
  endfunction : gp_port_mask

  // Whether a port slot and word index name a real register.
  function automatic logic gp_reg_exists(input logic [2:0] p, input logic [3:0] idx);
    if (p == GP_PORT_SYS) begin
      gp_reg_exists = (idx == GP_REG_SYS);
    end else if (p > 3'h4) begin
      gp_reg_exists = 1'b0;
    end else if (idx == GP_REG_ALT_FUNC_SET_FIRST || idx == GP_REG_ALT_FUNC_SET_SECOND) begin
      gp_reg_exists = (p != GP_PORT_D);
    end else if (idx == GP_REG_LED0 || idx == GP_REG_LED1) begin
      gp_reg_exists = (p == GP_PORT_C);
    end else begin
      gp_reg_exists = (idx <= GP_REG_IN);
    end
  endfunction : gp_reg_exists

endpackage : gp_pkg

// ### design/gp_port_mux.sv
// Five-port pin controller with alternate-function mux, AHB-Lite registers.
// Assumes pad_in comes from pins (synchronised here); peripheral and
// oscillator-control signals are on clk.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module gp_port_mux
  import gp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic xtal_en,
  input wire logic losc_en,
  input wire logic reset_drive_req,
  input wire logic [4:0][7:0] pad_in,
  output gp_port_ctl_t [4:0] pad_ctl,
  output logic [4:0][7:0] pin_level,
  output logic reset_pin_level,
  output logic wake_event,
  input wire logic timer0_compl_out,
  input wire logic timer0_compl_oe,
  input wire logic timer0_output,
  input wire logic uart0_driver_enable,
  input wire logic uart0_transmit_line,
  input wire logic timer1_compl_out,
  input wire logic timer1_compl_oe,
  input wire logic timer1_output,
  input wire logic timer2_compl_out,
  input wire logic timer2_compl_oe,
  input wire logic timer2_output,
  input wire logic i2c_scl_low,
  input wire logic i2c_sda_low,
  input wire logic [4:0][7:0] fn0_out,
  input wire logic [4:0][7:0] fn0_oe,
  input wire logic [4:0][7:0] fn1_out,
  input wire logic [4:0][7:0] fn1_oe,
  output logic timer0_capture_input,
  output logic uart0_clear_to_send,
  output logic uart0_receive_line,
  output logic timer1_capture_input,
  output logic timer2_capture_input,
  output logic i2c_scl_in,
  output logic i2c_sda_in,
  output logic ext_clock_input
);

  //////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] cfg_reg [0:4][0:8];
  logic [7:0] led0_reg;
  logic [7:0] led1_reg;
  logic rst_gpio_reg;
  logic wr_pend_reg;
  logic [2:0] wr_port_reg;
  logic [3:0] wr_idx_reg;
  logic [4:0][7:0] in_s1_reg;
  logic [4:0][7:0] in_s2_reg;
  logic [4:0][7:0] in_prev_reg;
  logic [4:0][7:0] alt_out;
  logic [4:0][7:0] alt_oe;
  logic [7:0] fa_out;
  logic [7:0] fa_oe;
  gp_port_ctl_t [4:0] ctl_next;
  logic [31:0] rd_next;
  logic accept;
  logic [2:0] a_port;
  logic [3:0] a_idx;
  logic [7:0] wmask;

  assign accept = hsel && hready && htrans == GP_HTRANS_NONSEQ;
  assign a_port = haddr[GP_PORT_LSB +: 3];
  assign a_idx = haddr[GP_IDX_LSB +: 4];
  assign wmask = gp_port_mask(wr_port_reg);

  // Single-cycle OKAY slave; write data is committed in its data phase.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_port_reg <= 3'h0;
      wr_idx_reg <= 4'h0;
    end else if (hready) begin
      wr_pend_reg <= accept && hwrite && gp_reg_exists(a_port, a_idx);
      wr_port_reg <= a_port;
      wr_idx_reg <= a_idx;
    end
  end

  // Each pin has its own bit; unimplemented pins and registers never store.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < GP_PORTS; p++) begin
        for (int r = 0; r < GP_CFG_REGS; r++) begin
          cfg_reg[p][r] <= (r == int'(GP_REG_DIR)) ?
                           (GP_DIR_RST & gp_port_mask(3'(p))) : GP_CFG_RST;
        end
      end
    end else if (wr_pend_reg && wr_port_reg != GP_PORT_SYS && wr_idx_reg < GP_REG_IN) begin
      cfg_reg[wr_port_reg][wr_idx_reg] <= hwdata[7:0] & wmask;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led0_reg <= GP_CFG_RST;
      led1_reg <= GP_CFG_RST;
      rst_gpio_reg <= 1'b0;
    end else if (wr_pend_reg) begin
      if (wr_port_reg == GP_PORT_C && wr_idx_reg == GP_REG_LED0) begin
        led0_reg <= hwdata[7:0];
      end
      if (wr_port_reg == GP_PORT_C && wr_idx_reg == GP_REG_LED1) begin
        led1_reg <= hwdata[7:0];
      end
      if (wr_port_reg == GP_PORT_SYS) begin
        rst_gpio_reg <= hwdata[GP_SYS_RST_GPIO_BIT];
      end
    end
  end

  // Read data is sampled in the address phase, so a read right behind a
  // write to the same word returns the old value.
  always_comb begin
    rd_next = 32'h0000_0000;
    if (a_port == GP_PORT_SYS && a_idx == GP_REG_SYS) begin
      rd_next[GP_SYS_RST_GPIO_BIT] = rst_gpio_reg;
      rd_next[GP_SYS_XTAL_BIT] = xtal_en;
      rd_next[GP_SYS_LOSC_BIT] = losc_en;
    end else if (gp_reg_exists(a_port, a_idx)) begin
      if (a_idx == GP_REG_IN) begin
        rd_next[7:0] = in_s2_reg[a_port] & gp_port_mask(a_port);
      end else if (a_idx == GP_REG_LED0) begin
        rd_next[7:0] = led0_reg;
      end else if (a_idx == GP_REG_LED1) begin
        rd_next[7:0] = led1_reg;
      end else begin
        rd_next[7:0] = cfg_reg[a_port][a_idx];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      hrdata <= rd_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers and wake detection.

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_s1_reg <= '0;
      in_s2_reg <= '0;
      in_prev_reg <= '0;
      wake_event <= 1'b0;
      pin_level <= '0;
      reset_pin_level <= 1'b1;
    end else begin
      in_s1_reg <= pad_in;
      in_s2_reg <= in_s1_reg;
      in_prev_reg <= in_s2_reg;
      pin_level <= in_s2_reg;
      reset_pin_level <= in_s2_reg[3][0];
      wake_event <= wake_any();
    end
  end

  function automatic logic wake_any();
    logic w;
    w = 1'b0;
    for (int p = 0; p < GP_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        w = w | (pad_ctl[p][b].wake & (in_s2_reg[p][b] ^ in_prev_reg[p][b]));
      end
    end
    return w;
  endfunction : wake_any

  //////////////////////////////////////////////////////////////////////////////
  // Alternate-function sources. Port A follows the fixed pin table.

  function automatic logic sel(input int p, input int b, input logic s);
    return cfg_reg[p][GP_REG_ALT][b] && cfg_reg[p][GP_REG_ALT_FUNC_SET_FIRST][b] == s;
  endfunction : sel

  always_comb begin
    fa_out = 8'h00;
    fa_oe = 8'h00;
    if (!cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][0]) begin
      fa_out[0] = timer0_compl_out;
      fa_oe[0] = timer0_compl_oe;
    end
    if (!cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][1]) begin
      fa_out[1] = timer0_output;
      fa_oe[1] = 1'b1;
    end
    if (!cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][2]) begin
      fa_out[2] = uart0_driver_enable;
      fa_oe[2] = 1'b1;
    end
    if (cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][4]) begin
      fa_out[4] = timer2_compl_out;
      fa_oe[4] = timer2_compl_oe;
    end
    fa_oe[5] = 1'b1;
    fa_out[5] = cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][5] ? timer2_output : uart0_transmit_line;
    if (cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][6]) begin
      fa_oe[6] = i2c_scl_low;
    end else begin
      fa_out[6] = timer1_compl_out;
      fa_oe[6] = timer1_compl_oe;
    end
    if (cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][7]) begin
      fa_oe[7] = i2c_sda_low;
    end else begin
      fa_out[7] = timer1_output;
      fa_oe[7] = 1'b1;
    end
  end

  // Port D has no set selector: its enable always picks bank zero.
  always_comb begin
    alt_out[0] = fa_out;
    alt_oe[0] = fa_oe;
    for (int p = 1; p < GP_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (p != int'(GP_PORT_D) && cfg_reg[p][GP_REG_ALT_FUNC_SET_FIRST][b]) begin
          alt_out[p][b] = fn1_out[p][b];
          alt_oe[p][b] = fn1_oe[p][b];
        end else begin
          alt_out[p][b] = fn0_out[p][b];
          alt_oe[p][b] = fn0_oe[p][b];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-pin pad control, then overrides in priority order.

  always_comb begin
    for (int p = 0; p < GP_PORTS; p++) begin
      for (int b = 0; b < 8; b++) begin
        ctl_next[p][b] = '0;
        ctl_next[p][b].od = cfg_reg[p][GP_REG_OD][b];
        ctl_next[p][b].hd = cfg_reg[p][GP_REG_HD][b];
        ctl_next[p][b].pu = cfg_reg[p][GP_REG_PU][b];
        ctl_next[p][b].wake = cfg_reg[p][GP_REG_WAKE][b];
        if (cfg_reg[p][GP_REG_ALT][b]) begin
          if (p == int'(GP_PORT_C) && cfg_reg[p][GP_REG_ALT_FUNC_SET_FIRST][b]) begin
            ctl_next[p][b].led_en = 1'b1;
            ctl_next[p][b].led_lvl = {led1_reg[b], led0_reg[b]};
          end else begin
            ctl_next[p][b].out = alt_out[p][b];
            ctl_next[p][b].oe = alt_oe[p][b];
          end
        end else begin
          ctl_next[p][b].out = cfg_reg[p][GP_REG_OUT][b];
          ctl_next[p][b].oe = !cfg_reg[p][GP_REG_DIR][b];
        end
        if (p == int'(GP_PORT_D) && b == 0) begin
          ctl_next[p][b].wake = 1'b0;
          if (!rst_gpio_reg) begin
            ctl_next[p][b].out = 1'b0;
            ctl_next[p][b].oe = reset_drive_req;
            ctl_next[p][b].od = 1'b1;
            ctl_next[p][b].pu = 1'b1;
            ctl_next[p][b].led_en = 1'b0;
          end
        end
        if (p == int'(GP_PORT_A) && ((b < 2 && xtal_en) || (b >= 2 && b < 4 && losc_en))) begin
          ctl_next[p][b] = '0;
        end
        if ((gp_port_mask(3'(p)) & (8'h01 << b)) == 8'h00) begin
          ctl_next[p][b] = '0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_ctl <= '0;
    end else begin
      pad_ctl <= ctl_next;
    end
  end

  // Pin levels handed to peripherals are held low unless the function is picked.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer0_capture_input <= 1'b0;
      uart0_clear_to_send <= 1'b0;
      uart0_receive_line <= 1'b0;
      timer1_capture_input <= 1'b0;
      timer2_capture_input <= 1'b0;
      i2c_scl_in <= 1'b0;
      i2c_sda_in <= 1'b0;
      ext_clock_input <= 1'b0;
    end else begin
      timer0_capture_input <= sel(0, 0, 1'b0) && !xtal_en && in_s2_reg[0][0];
      uart0_clear_to_send <= sel(0, 3, 1'b0) && !losc_en && in_s2_reg[0][3];
      uart0_receive_line <= sel(0, 4, 1'b0) && in_s2_reg[0][4];
      timer2_capture_input <= sel(0, 4, 1'b1) && in_s2_reg[0][4];
      timer1_capture_input <= sel(0, 6, 1'b0) && in_s2_reg[0][6];
      i2c_scl_in <= sel(0, 6, 1'b1) && in_s2_reg[0][6];
      i2c_sda_in <= sel(0, 7, 1'b1) && in_s2_reg[0][7];
      ext_clock_input <= sel(1, 3, 1'b0) && in_s2_reg[1][3];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_xtal;
    xtal_en |=> !pad_ctl[0][0].oe && !pad_ctl[0][1].oe && !pad_ctl[0][1].pu;
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pins still driven");

  property p_losc;
    losc_en |=> pad_ctl[0][2] == '0 && pad_ctl[0][3] == '0;
  endproperty
  a_losc: assert property (p_losc) else $error("watch crystal pins not released");

  property p_led;
    cfg_reg[2][GP_REG_ALT][3] && cfg_reg[2][GP_REG_ALT_FUNC_SET_FIRST][3]
      |=> pad_ctl[2][3].led_en && !pad_ctl[2][3].oe
          && pad_ctl[2][3].led_lvl == $past({led1_reg[3], led0_reg[3]});
  endproperty
  a_led: assert property (p_led) else $error("LED mode not entered");

  property p_rst_pin;
    !rst_gpio_reg |=> pad_ctl[3][0].od && pad_ctl[3][0].pu
                      && pad_ctl[3][0].oe == $past(reset_drive_req);
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset pin not in reset mode");

  property p_rst_nowake;
    cfg_reg[3][GP_REG_WAKE][0] |=> !pad_ctl[3][0].wake;
  endproperty
  a_rst_nowake: assert property (p_rst_nowake) else $error("reset pin wake enabled");

  property p_gpio_out;
    !cfg_reg[1][GP_REG_ALT][0] && !cfg_reg[1][GP_REG_DIR][0]
      |=> pad_ctl[1][0].oe && pad_ctl[1][0].out == $past(cfg_reg[1][GP_REG_OUT][0]);
  endproperty
  a_gpio_out: assert property (p_gpio_out) else $error("output pin not driving data");

  // Properties name the select bits directly so that they see sampled values.
  property p_scl;
    cfg_reg[0][GP_REG_ALT][6] && cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][6]
      |=> pad_ctl[0][6].oe == $past(i2c_scl_low) && !pad_ctl[0][6].out;
  endproperty
  a_scl: assert property (p_scl) else $error("clock line not under bus control");

  property p_t0_reserved;
    cfg_reg[0][GP_REG_ALT][1] && cfg_reg[0][GP_REG_ALT_FUNC_SET_FIRST][1] && !xtal_en
      |=> !pad_ctl[0][1].oe;
  endproperty
  a_t0_reserved: assert property (p_t0_reserved) else $error("reserved select drives");

  property p_ext_clk;
    (cfg_reg[1][GP_REG_ALT][3] && !cfg_reg[1][GP_REG_ALT_FUNC_SET_FIRST][3]) [*4]
      |-> ext_clock_input == $past(pad_in[1][3], 3);
  endproperty
  a_ext_clk: assert property (p_ext_clk) else $error("clock input path broken");

  property p_portd_fn;
    cfg_reg[3][GP_REG_ALT][1] |=> pad_ctl[3][1].oe == $past(fn0_oe[3][1]);
  endproperty
  a_portd_fn: assert property (p_portd_fn) else $error("port D function not taken");

  c_led: cover property (cfg_reg[2][GP_REG_ALT][3] ##1 pad_ctl[2][3].led_en);
  c_rst_gpio: cover property (!rst_gpio_reg ##1 rst_gpio_reg);
  c_ext_clk: cover property (cfg_reg[1][GP_REG_ALT][3] ##3 ext_clock_input);

endmodule : gp_port_mux

// ### sim/gp_pin_model.sv
// Board-side pin model: resolves every pad from the block's drive, the board and pulls.
// Assumes pad_ctl comes straight from the block; the bench sets the board drivers.
`timescale 1ns/100ps
module gp_pin_model
  import gp_pkg::*;
(
  input wire logic clk,
  input wire gp_port_ctl_t [4:0] pad_ctl,
  input wire logic [4:0][7:0] board_drv,
  input wire logic [4:0][7:0] board_val,
  output logic [4:0][7:0] pad_in
);
  logic flip_reg;

  initial flip_reg = 1'h0;

  // A floating pad must not keep its last level, or a stale value could pass a check.
  always @(posedge clk) begin
    flip_reg <= ~flip_reg;
  end

  always_comb begin
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (pad_ctl[p][b].oe && !(pad_ctl[p][b].od && pad_ctl[p][b].out)) begin
          pad_in[p][b] = pad_ctl[p][b].out;
        end else if (board_drv[p][b]) begin
          pad_in[p][b] = board_val[p][b];
        end else if (pad_ctl[p][b].pu) begin
          pad_in[p][b] = 1'h1;
        end else begin
          pad_in[p][b] = flip_reg ^ b[0];
        end
      end
    end
  end
endmodule : gp_pin_model

// ### sim/gpio_port_altfunc_mux_tb.sv
// Bench for the port block: reset-pin checks first, then register rows, then pin and mux scenarios.
// Assumes gp_pin_model closes the loop from pad_ctl back to pad_in.
`timescale 1ns/100ps
module gpio_port_altfunc_mux_tb
  import gp_pkg::*;
;
  typedef struct {
    logic wr;
    logic [2:0] p;
    logic [3:0] i;
    logic [7:0] d;
    logic [7:0] e;
  } gp_row_t;
  logic clk, rstn, hsel, hwrite, xtal_en, losc_en, reset_drive_req;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, reset_pin_level, wake_event;
  wire logic hready;
  // Sources: t0 compl out/oe, t0 out, de, tx, t1 compl out/oe, t1 out,
  // t2 compl out/oe, t2 out, scl low, sda low.
  logic [12:0] src;
  logic [7:0] cap;
  logic [4:0][7:0] pad_in, pin_level, fn0_out, fn0_oe, fn1_out, fn1_oe, bdrv, bval;
  gp_port_ctl_t [4:0] pad_ctl;
  int num_errors, checks;
  logic [1:0] lv[4] = '{GP_LED_3MA, GP_LED_7MA, GP_LED_13MA, GP_LED_20MA};
  gp_row_t rows[15] = '{
    '{1'h0, GP_PORT_A, GP_REG_DIR, 8'h00, 8'hFF},
    '{1'h0, GP_PORT_B, GP_REG_DIR, 8'h00, 8'h3F},
    '{1'h0, 3'h4, GP_REG_DIR, 8'h00, 8'h7F},
    '{1'h0, GP_PORT_A, GP_REG_OUT, 8'h00, 8'h00},
    '{1'h0, GP_PORT_SYS, GP_REG_SYS, 8'h00, 8'h00},
    '{1'h1, GP_PORT_A, GP_REG_DIR, 8'h5A, 8'h5A},
    '{1'h1, GP_PORT_B, GP_REG_OD, 8'hFF, 8'h3F},
    '{1'h1, 3'h4, GP_REG_HD, 8'hFF, 8'h7F},
    '{1'h1, GP_PORT_C, GP_REG_PU, 8'h0F, 8'h0F},
    '{1'h1, GP_PORT_A, GP_REG_WAKE, 8'hF0, 8'hF0},
    '{1'h1, GP_PORT_D, GP_REG_ALT_FUNC_SET_FIRST, 8'hFF, 8'h00},
    '{1'h1, GP_PORT_A, GP_REG_ALT_FUNC_SET_SECOND, 8'hC3, 8'hC3},
    '{1'h1, 3'h6, 4'h0, 8'hFF, 8'h00},
    '{1'h1, GP_PORT_C, GP_REG_LED1, 8'h33, 8'h33},
    '{1'h1, GP_PORT_B, GP_REG_DIR, 8'h00, 8'h00}
  };

  assign hready = hreadyout;

  gp_port_mux u_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .xtal_en(xtal_en),
    .losc_en(losc_en), .reset_drive_req(reset_drive_req), .pad_in(pad_in),
    .pad_ctl(pad_ctl), .pin_level(pin_level), .reset_pin_level(reset_pin_level),
    .wake_event(wake_event), .timer0_compl_out(src[0]), .timer0_compl_oe(src[1]),
    .timer0_output(src[2]), .uart0_driver_enable(src[3]),
    .uart0_transmit_line(src[4]), .timer1_compl_out(src[5]),
    .timer1_compl_oe(src[6]), .timer1_output(src[7]), .timer2_compl_out(src[8]),
    .timer2_compl_oe(src[9]), .timer2_output(src[10]), .i2c_scl_low(src[11]),
    .i2c_sda_low(src[12]), .fn0_out(fn0_out), .fn0_oe(fn0_oe), .fn1_out(fn1_out),
    .fn1_oe(fn1_oe), .timer0_capture_input(cap[0]), .uart0_clear_to_send(cap[1]),
    .uart0_receive_line(cap[2]), .timer1_capture_input(cap[3]),
    .timer2_capture_input(cap[4]), .i2c_scl_in(cap[5]), .i2c_sda_in(cap[6]),
    .ext_clock_input(cap[7])
  );

  gp_pin_model u_pins (
    .clk(clk), .pad_ctl(pad_ctl), .board_drv(bdrv), .board_val(bval), .pad_in(pad_in)
  );

////////////////////////////////////////////////////////////////////////////////

  task automatic test_done;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask : ck

  // Waits for hready at a rising edge; a slave that never answers ends the run.
  task automatic rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'h1) begin
      n++;
      if (n > 40) begin
        num_errors++;
        test_done;
      end
      @(posedge clk);
    end
  endtask : rdy

  task automatic bus(input logic wr, input logic [2:0] p, input logic [3:0] i,
                     input logic [7:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= GP_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {23'h0, p, i, 2'h0};
    rdy;
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= {24'h0, d};
    rdy;
    rd = hrdata;
  endtask : bus

  task automatic w(input logic [2:0] p, input logic [3:0] i, input logic [7:0] d);
    bus(1'h1, p, i, d, q);
  endtask : w

  task automatic r(input string nm, input logic [2:0] p, input logic [3:0] i,
                   input logic [7:0] e);
    bus(1'h0, p, i, 8'h00, q);
    ck(nm, q, {24'h0, e});
  endtask : r

  task automatic st(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : st

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    rstn = 1'h0;
    {hsel, hwrite, xtal_en, losc_en, reset_drive_req, src} = '0;
    {haddr, hwdata, htrans, fn0_out, fn0_oe, fn1_out, fn1_oe, bdrv, bval} = '0;
    hsize = 3'h2;
    num_errors = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'h1;
    // The pull-up needs three more edges to reach the level output.
    st(4);
    ck("rp_od", pad_ctl[3][0].od, 1);
    ck("rp_pu", pad_ctl[3][0].pu, 1);
    ck("rp_lvl", reset_pin_level, 1);
    for (int k = 0; k < 15; k++) begin
      if (rows[k].wr) begin
        w(rows[k].p, rows[k].i, rows[k].d);
      end
      r($sformatf("row%0d", k), rows[k].p, rows[k].i, rows[k].e);
    end
    st(1);
    ck("hresp", {hreadyout, hresp}, 2'h2);
    ck("b7_oe", pad_ctl[1][7].oe, 0);
    ck("b5_oe", pad_ctl[1][5].oe, 1);
    @(posedge clk);
    reset_drive_req <= 1'h1;
    st(5);
    ck("rp_drv", pad_ctl[3][0].oe, 1);
    ck("rp_low", reset_pin_level, 0);
    @(posedge clk);
    reset_drive_req <= 1'h0;
    st(5);
    ck("rp_high", reset_pin_level, 1);
    w(GP_PORT_D, GP_REG_WAKE, 8'h01);
    w(GP_PORT_D, GP_REG_HD, 8'h01);
    w(GP_PORT_D, GP_REG_DIR, 8'hFE);
    w(GP_PORT_D, GP_REG_OUT, 8'h01);
    w(GP_PORT_SYS, GP_REG_SYS, 8'h01);
    st(1);
    ck("rp_wake", pad_ctl[3][0].wake, 0);
    ck("rp_hd", pad_ctl[3][0].hd, 1);
    ck("rp_gpio", {pad_ctl[3][0].oe, pad_ctl[3][0].od, pad_ctl[3][0].out}, 3'h5);
    w(GP_PORT_C, GP_REG_DIR, 8'hFE);
    w(GP_PORT_C, GP_REG_OUT, 8'h01);
    @(posedge clk);
    bdrv[2][1] <= 1'h1;
    bval[2][1] <= 1'h1;
    st(5);
    ck("c0_pin", pin_level[2][0], 1);
    ck("c1_pin", pin_level[2][1], 1);
    @(posedge clk);
    bval[2][1] <= 1'h0;
    st(5);
    ck("c1_pin", pin_level[2][1], 0);
    w(GP_PORT_C, GP_REG_ALT, 8'h08);
    w(GP_PORT_C, GP_REG_ALT_FUNC_SET_FIRST, 8'h08);
    for (int k = 0; k < 4; k++) begin
      w(GP_PORT_C, GP_REG_LED0, {8{lv[k][0]}});
      w(GP_PORT_C, GP_REG_LED1, {8{lv[k][1]}});
      st(1);
      ck("led", {pad_ctl[2][3].led_en, pad_ctl[2][3].led_lvl}, {1'h1, lv[k]});
    end
    w(GP_PORT_C, GP_REG_ALT_FUNC_SET_FIRST, 8'h00);
    st(1);
    ck("led_off", pad_ctl[2][3].led_en, 0);
    w(GP_PORT_A, GP_REG_DIR, 8'hFF);
    w(GP_PORT_A, GP_REG_ALT_FUNC_SET_FIRST, 8'h00);
    w(GP_PORT_A, GP_REG_ALT, 8'hC3);
    @(posedge clk);
    src <= 13'h1083;
    bdrv[0][7:3] <= 5'h1F;
    bval[0][7:3] <= 5'h1F;
    st(5);
    ck("a0", {pad_ctl[0][0].oe, pad_ctl[0][0].out}, 2'h3);
    ck("timer0_capture_input", cap[0], 1);
    ck("a7", pad_ctl[0][7].out, 1);
    ck("timer1_capture_input", cap[3], 1);
    w(GP_PORT_A, GP_REG_ALT_FUNC_SET_FIRST, 8'hC3);
    @(posedge clk);
    src <= 13'h0800;
    st(5);
    ck("a0_rsv", pad_ctl[0][0].oe, 0);
    ck("a1_rsv", pad_ctl[0][1].oe, 0);
    ck("scl", {pad_ctl[0][6].oe, pad_ctl[0][6].out}, 2'h2);
    ck("sda", cap[6], 1);
    ck("t1off", cap[3], 0);
    w(GP_PORT_A, GP_REG_ALT, 8'h00);
    st(5);
    ck("sda_off", cap[6], 0);
    w(GP_PORT_A, GP_REG_ALT_FUNC_SET_FIRST, 8'h00);
    w(GP_PORT_A, GP_REG_ALT, 8'h3C);
    @(posedge clk);
    src <= 13'h0018;
    st(5);
    ck("de", pad_ctl[0][2].out, 1);
    ck("cts", cap[1], 1);
    ck("rxd", cap[2], 1);
    ck("txd", pad_ctl[0][5].out, 1);
    w(GP_PORT_A, GP_REG_ALT_FUNC_SET_FIRST, 8'h30);
    @(posedge clk);
    src <= 13'h0400;
    st(5);
    ck("timer2_output", pad_ctl[0][5].out, 1);
    ck("timer2_capture_input", cap[4], 1);
    ck("rxd_off", cap[2], 0);
    w(GP_PORT_A, GP_REG_ALT, 8'h00);
    w(GP_PORT_A, GP_REG_DIR, 8'h00);
    @(posedge clk);
    xtal_en <= 1'h1;
    st(2);
    ck("xtal", {pad_ctl[0][2].oe, pad_ctl[0][1].oe, pad_ctl[0][0].oe}, 3'h4);
    @(posedge clk);
    losc_en <= 1'h1;
    st(2);
    ck("losc", {pad_ctl[0][4].oe, pad_ctl[0][3].oe, pad_ctl[0][2].oe}, 3'h4);
    r("sys", GP_PORT_SYS, GP_REG_SYS, 8'h07);
    w(GP_PORT_D, GP_REG_ALT, 8'h02);
    @(posedge clk);
    fn0_oe[3][1] <= 1'h1;
    fn0_out[3][1] <= 1'h1;
    st(2);
    ck("d1", {pad_ctl[3][1].oe, pad_ctl[3][1].out}, 2'h3);
    w(GP_PORT_B, GP_REG_DIR, 8'hFF);
    w(GP_PORT_B, GP_REG_ALT_FUNC_SET_FIRST, 8'h00);
    w(GP_PORT_B, GP_REG_ALT, 8'h08);
    @(posedge clk);
    bdrv[1][3] <= 1'h1;
    bval[1][3] <= 1'h1;
    st(5);
    ck("ext_clock_input", cap[7], 1);
    w(GP_PORT_B, GP_REG_ALT_FUNC_SET_FIRST, 8'h08);
    st(5);
    ck("ext_clock_input_off", cap[7], 0);
    w(GP_PORT_B, GP_REG_WAKE, 8'h08);
    st(3);
    ck("wake_idle", wake_event, 0);
    @(posedge clk);
    bval[1][3] <= 1'h0;
    st(3);
    ck("wake", wake_event, 1);
    // A second reset in mid-run must bring the shared pin back to reset mode.
    @(posedge clk);
    rstn <= 1'h0;
    st(2);
    ck("rst_ctl", pad_ctl[3][0].od, 0);
    @(posedge clk);
    rstn <= 1'h1;
    st(1);
    ck("rst_od", pad_ctl[3][0].od, 1);
    r("rst_sys", GP_PORT_SYS, GP_REG_SYS, 8'h06);
    test_done;
  end
endmodule : gpio_port_altfunc_mux_tb
